// ===== logic/amcr_mode_regs.sv
// Mode configuration register bank with start-delay sequencer and aux pins.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Bits 6:5 pick excitation; normal default.
// - Bit 4 zero runs back to back.
// - Bits 3:0 select conversion start delay.
// - Delay resets to code one; 14,15 reserved.
// - Connect bit n joins pin n.
// - Direction bit n: zero output, one input.
// - Level bits hold pin levels, reset low.
// - Power-down bit stops all conversions.
// - Status-byte option follows its bit.
// - Check-code option follows its bit.
// - Serial auto-reset option follows its bit.
// - Status shows new data and alarms.
module amcr_mode_regs
  import amcr_pkg::*;
#(
  parameter amcr_dly_tab_t DELAY_CYC = DLY_CYC  // Delay per code in cycles.
)(
  input  wire logic              ref_clk,     // 25 MHz clock.
  input  wire logic              rst_b,       // Asynchronous reset, active low.
  input  wire logic [7:0]        regAddr,     // Register address.
  input  wire logic [7:0]        regWrData,   // Write data.
  input  wire logic              regWr,       // Write strobe.
  input  wire logic              regRd,       // Read strobe.
  output var  logic [7:0]        regRdData,   // Read data, one cycle later.
  input  wire logic              startPin,    // Conversion start level.
  input  wire logic              convDone,    // Modulator finished a result.
  input  wire logic              dataRead,    // Host read the conversion data.
  input  wire amcr_alarm_t       alarmIn,     // Live alarm levels.
  input  wire logic [AUX_N-1:0]  auxPinIn,    // Aux pin levels.
  output var  logic [AUX_N-1:0]  auxPinOut,   // Aux pin drive levels.
  output var  logic [AUX_N-1:0]  auxPinOe,    // Aux pin output enables.
  output var  logic [AUX_N-1:0]  auxConnect,  // Aux function joined to input.
  output var  amcr_cfg_t         cfgOut,      // Decoded configuration.
  output var  logic              convKick,    // One-cycle conversion start.
  output var  logic              convBusy     // Sequencer not idle.
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0]  rstPipe;    // Two-stage release of the reset.
  logic        rstSync;    // Reset used by the rest of the block.
  amcr_state_t stateReg;   // All block state except the reset pipe and the assertion counters.
  amcr_state_t stateNext;  // Next value of the block state.

  // Asserts at once, releases after two edges so no flop sees a runt release.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstPipe <= 2'h0;
    end
    else
    begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  logic       startRise;  // Start level went from low to high.
  logic [3:0] dlyCode;    // Delay code with reserved codes clamped.
  logic [3:0] auxCon;     // Connect bits of the aux configuration.
  logic [3:0] auxDir;     // Direction bits of the aux configuration.
  logic [3:0] levelRd;    // Level bits as the host reads them.
  logic       runReq;     // Start condition for the current mode.

  // Computes register writes, read data, flags and the sequencer step.
  always_comb
  begin
    stateNext          = stateReg;
    stateNext.convKick = 1'b0;
    stateNext.rdData   = 8'h00;
    stateNext.auxInSmp = auxPinIn;
    stateNext.startPrev = startPin;
    startRise = startPin & ~stateReg.startPrev;
    auxCon    = stateReg.auxCfg[AUX_CON_LO +: AUX_N];
    auxDir    = stateReg.auxCfg[AUX_N-1:0];
    // Input pins read their sampled level, outputs the written one.
    levelRd   = (auxDir & stateReg.auxInSmp) | (~auxDir & stateReg.pwrIf[3:0]);
    // Reserved delay codes act as the longest defined delay.
    dlyCode   = (stateReg.convMode[3:0] > DLY_LAST) ? DLY_LAST
              : stateReg.convMode[3:0];
    // Continuous mode runs while start is high, one-shot on each rise.
    runReq    = stateReg.cfg.singleShot ? startRise : startPin;

    // Register writes; unmapped addresses are ignored.
    if (regWr)
    begin
      unique case (regAddr)
        // The reserved bit is forced low in case the host breaks its promise.
        ADDR_CONV_MODE: stateNext.convMode = regWrData & ~(8'h01 << CM_RSVD);
        ADDR_AUX_CFG:   stateNext.auxCfg = regWrData;
        ADDR_PWR_IF:    stateNext.pwrIf = regWrData;
        default:        stateNext.auxCfg = stateReg.auxCfg;
      endcase
    end

    // Register reads; unmapped addresses read zero.
    if (regRd)
    begin
      unique case (regAddr)
        ADDR_STATUS:
        begin
          stateNext.rdData[ST_PGA_LOW]  = stateReg.alarm.pgaLow;
          stateNext.rdData[ST_PGA_HIGH] = stateReg.alarm.pgaHigh;
          stateNext.rdData[ST_REF_LOW]  = stateReg.alarm.refLow;
          stateNext.rdData[ST_NEW_DATA] = stateReg.newData;
        end
        ADDR_CONV_MODE: stateNext.rdData = stateReg.convMode;
        ADDR_AUX_CFG:   stateNext.rdData = stateReg.auxCfg;
        ADDR_PWR_IF:    stateNext.rdData = {stateReg.pwrIf[7:4], levelRd};
        default:        stateNext.rdData = 8'h00;
      endcase
    end

    // Sequencer: optional start delay, then one kick per conversion.
    unique case (stateReg.seq)
      SEQ_IDLE:
      begin
        if (runReq)
        begin
          stateNext.seq    = SEQ_DELAY;
          stateNext.dlyCnt = amcr_dcnt_t'(DELAY_CYC[dlyCode]);
        end
      end
      SEQ_DELAY:
      begin
        if (!stateReg.cfg.singleShot && !startPin)
        begin
          stateNext.seq = SEQ_IDLE;  // Start dropped before the kick.
        end
        else if (stateReg.dlyCnt == '0)
        begin
          stateNext.seq      = SEQ_CONV;
          stateNext.convKick = 1'b1;
        end
        else
        begin
          stateNext.dlyCnt = stateReg.dlyCnt - amcr_dcnt_t'(1);
        end
      end
      SEQ_CONV:
      begin
        if (convDone)
        begin
          if (!stateReg.cfg.singleShot && startPin)
          begin
            stateNext.seq    = SEQ_DELAY;
            stateNext.dlyCnt = amcr_dcnt_t'(DELAY_CYC[dlyCode]);
          end
          else
          begin
            stateNext.seq = SEQ_IDLE;
          end
        end
      end
      default: stateNext.seq = SEQ_IDLE;
    endcase
    // Power-down halts the sequencer wherever it stands.
    if (stateNext.pwrIf[PI_PDN])
    begin
      stateNext.seq      = SEQ_IDLE;
      stateNext.convKick = 1'b0;  // A kick due in the same cycle is dropped too.
    end

    // New-data flag: a result in the same cycle as a read still sets it.
    if (dataRead)
    begin
      stateNext.newData = 1'b0;
    end
    if (stateReg.seq == SEQ_CONV && convDone)
    begin
      stateNext.newData = 1'b1;
    end
    // Alarms restart at each conversion start; a live alarm wins the clear.
    stateNext.alarm = (stateNext.convKick ? '0 : stateReg.alarm) | alarmIn;

    // Registered copies of the decoded outputs.
    stateNext.convBusy   = (stateNext.seq != SEQ_IDLE);
    stateNext.cfg.excitation = amcr_exc_t'(stateNext.convMode[CM_EXC_LO +: 2]);
    stateNext.cfg.singleShot = stateNext.convMode[CM_SINGLE];
    stateNext.cfg.startDelay = stateNext.convMode[3:0];
    stateNext.cfg.powerDown  = stateNext.pwrIf[PI_PDN];
    stateNext.cfg.statusByteEn      = stateNext.pwrIf[PI_STAT];
    stateNext.cfg.checkCodeEn       = stateNext.pwrIf[PI_CRC];
    stateNext.cfg.serialAutoResetEn = stateNext.pwrIf[PI_SAR];
    // A pin drives only when connected and set as an output.
    stateNext.auxOe  = stateNext.auxCfg[AUX_CON_LO +: AUX_N]
                     & ~stateNext.auxCfg[AUX_N-1:0];
    stateNext.auxOut = stateNext.auxOe & stateNext.pwrIf[3:0];
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Loads the documented reset values, then follows the next state.
  always_ff @(posedge ref_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      stateReg                <= '0;
      stateReg.convMode       <= RST_CONV_MODE;
      stateReg.auxCfg         <= RST_AUX_CFG;
      stateReg.pwrIf          <= RST_PWR_IF;
      stateReg.cfg.startDelay <= RST_CONV_MODE[3:0];
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  // Outputs come straight from the state register.
  assign regRdData  = stateReg.rdData;
  assign auxPinOut  = stateReg.auxOut;
  assign auxPinOe   = stateReg.auxOe;
  assign auxConnect = stateReg.auxCfg[AUX_CON_LO +: AUX_N];
  assign cfgOut     = stateReg.cfg;
  assign convKick   = stateReg.convKick;
  assign convBusy   = stateReg.convBusy;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstSync);

  amcr_dcnt_t dlyElapsed;  // Cycles spent waiting in the delay state.
  logic [3:0] dlyCodeHeld;  // Clamped code used for the current wait.

  // Counts the wait so the kick time can be checked against the table.
  always_ff @(posedge ref_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      dlyElapsed  <= '0;
      dlyCodeHeld <= 4'h0;
    end
    else if (stateReg.seq != SEQ_DELAY)
    begin
      dlyElapsed  <= '0;
      dlyCodeHeld <= dlyCode;
    end
    else
    begin
      dlyElapsed <= dlyElapsed + amcr_dcnt_t'(1);
    end
  end

  // One result accepted while converting.
  sequence convEnd;
    stateReg.seq == SEQ_CONV && convDone;
  endsequence

  // Start held high in continuous mode with power on.
  sequence runOn;
    !stateReg.cfg.singleShot && startPin && !stateNext.pwrIf[PI_PDN];
  endsequence

  // A fresh start edge seen by an idle, powered one-shot sequencer.
  sequence shotStart;
    stateReg.seq == SEQ_IDLE && stateReg.cfg.singleShot && startRise
    && !stateNext.pwrIf[PI_PDN];
  endsequence

  // Excitation output tracks its field.
  a_exc_decode: assert property (cfgOut.excitation == stateReg.convMode[6:5])
    else $error("Excitation output differs from its field.");

  // A one-shot conversion ends in idle.
  a_single_stop: assert property (convEnd ##0 stateReg.cfg.singleShot |=> !convBusy)
    else $error("One-shot conversion did not stop.");

  // A one-shot start edge wakes the sequencer.
  a_shot_start: assert property (shotStart |=> convBusy)
    else $error("One-shot start edge was not taken.");

  // Continuous mode starts the next delay after a result.
  a_cont_rerun: assert property (convEnd ##0 runOn |=> stateReg.seq == SEQ_DELAY)
    else $error("Continuous conversion did not restart.");

  // Dropping start during a continuous delay returns to idle.
  a_delay_abort: assert property (stateReg.seq == SEQ_DELAY && !stateReg.cfg.singleShot
    && !startPin |=> !convBusy)
    else $error("Continuous delay not abandoned.");

  // The kick comes the table length plus one cycle after the delay began.
  a_delay_time: assert property ($rose(convKick) |->
    dlyElapsed == amcr_dcnt_t'(DELAY_CYC[dlyCodeHeld]) + amcr_dcnt_t'(1))
    else $error("Start delay length is wrong.");

  // The kick lasts one cycle.
  a_kick_pulse: assert property (convKick |=> !convKick)
    else $error("Conversion kick longer than one cycle.");

  // The reserved bit never holds a one.
  a_rsvd_zero: assert property (!stateReg.convMode[CM_RSVD])
    else $error("Reserved mode bit became set.");

  // Mode register reads return the stored byte.
  a_conv_readback: assert property (regRd && regAddr == ADDR_CONV_MODE |=>
    regRdData == $past(stateReg.convMode))
    else $error("Mode register read back is wrong.");

  // Output enables follow connect and direction.
  a_aux_enable: assert property (##1 auxPinOe == (auxConnect & ~stateReg.auxCfg[3:0]))
    else $error("Aux output enable wrong for connect and direction.");

  // Aux configuration reads return the stored byte.
  a_aux_readback: assert property (regRd && regAddr == ADDR_AUX_CFG |=>
    regRdData == $past(stateReg.auxCfg))
    else $error("Aux configuration read back is wrong.");

  // Only connected outputs drive their written level.
  a_aux_drive: assert property (auxPinOut == (auxCon & ~auxDir & stateReg.pwrIf[3:0]))
    else $error("Aux drive level is wrong.");

  // Level reads mix sampled inputs and written outputs.
  a_level_read: assert property (regRd && regAddr == ADDR_PWR_IF |=>
    regRdData[3:0] == (($past(auxDir) & $past(stateReg.auxInSmp))
                     | (~$past(auxDir) & $past(stateReg.pwrIf[3:0]))))
    else $error("Aux level read back is wrong.");

  // A write to the power register lands whole.
  a_write_lands: assert property (regWr && regAddr == ADDR_PWR_IF |=>
    stateReg.pwrIf == $past(regWrData))
    else $error("Power register write was lost.");

  // Nothing converts while powered down.
  a_power_idle: assert property (cfgOut.powerDown |-> !convBusy && !convKick)
    else $error("Conversion ran during power-down.");

  // Data option outputs follow their bits.
  a_option_bits: assert property ({cfgOut.statusByteEn, cfgOut.checkCodeEn,
    cfgOut.serialAutoResetEn} == stateReg.pwrIf[6:4])
    else $error("Data option outputs differ from their bits.");

  // A result marks the data as new.
  a_new_data: assert property (convEnd |=> stateReg.newData)
    else $error("New-data flag not set by a result.");

  // Status reads show the new-data flag.
  a_status_read: assert property (regRd && regAddr == ADDR_STATUS |=>
    regRdData[ST_NEW_DATA] == $past(stateReg.newData))
    else $error("Status read shows the wrong new-data flag.");

  // Alarms restart from the live levels at each kick.
  a_alarm_restart: assert property (convKick |-> stateReg.alarm == $past(alarmIn))
    else $error("Alarms not restarted at conversion start.");

endmodule
`default_nettype wire

// ===== shared/amcr_pkg.sv
// Constants and carrier types shared by the mode configuration register bank.
`default_nettype none
package amcr_pkg;

  // ==========================================================================
  // Register map and reset values
  // ==========================================================================
  localparam logic [7:0] ADDR_STATUS    = 8'h01;  // Status: new data and alarms.
  localparam logic [7:0] ADDR_CONV_MODE = 8'h03;  // Excitation, mode and delay.
  localparam logic [7:0] ADDR_AUX_CFG   = 8'h04;  // Aux pin connect and direction.
  localparam logic [7:0] ADDR_PWR_IF    = 8'h05;  // Power, options and pin levels.
  localparam logic [7:0] RST_CONV_MODE  = 8'h01;  // Start delay code one.
  localparam logic [7:0] RST_AUX_CFG    = 8'h00;  // All pins unconnected outputs.
  localparam logic [7:0] RST_PWR_IF     = 8'h00;  // Running, options off, low.

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CM_RSVD     = 7;  // Reserved bit, held at zero.
  localparam int CM_EXC_LO   = 5;  // Excitation field is bits 6:5.
  localparam int CM_SINGLE   = 4;  // One-shot conversion select.
  localparam int AUX_CON_LO  = 4;  // Connect bits are 7:4, direction 3:0.
  localparam int PI_PDN      = 7;  // Software power-down.
  localparam int PI_STAT     = 6;  // Status byte in data reads.
  localparam int PI_CRC      = 5;  // Check code on data.
  localparam int PI_SAR      = 4;  // Serial auto reset.
  localparam int ST_PGA_LOW  = 5;  // Amplifier low alarm.
  localparam int ST_PGA_HIGH = 4;  // Amplifier high alarm.
  localparam int ST_REF_LOW  = 3;  // Reference low alarm.
  localparam int ST_NEW_DATA = 2;  // Conversion data new since last read.
  localparam int AUX_N       = 4;  // Number of auxiliary pins.

  // ==========================================================================
  // Conversion start delay
  // ==========================================================================
  localparam int unsigned CLK_MHZ   = 25;  // Rate of ref_clk.
  localparam int unsigned DLY_CODES = 14;  // Codes 0 to 13 are defined.
  localparam logic [3:0]  DLY_LAST  = 4'hD;  // Highest defined delay code.
  localparam int          DLY_CNT_W = 19;  // Wide enough for the longest delay.
  typedef int unsigned amcr_dly_tab_t [DLY_CODES];
  typedef logic [DLY_CNT_W-1:0] amcr_dcnt_t;
  // Delay per code in nanoseconds.
  localparam amcr_dly_tab_t DLY_NS = '{0, 50000, 59000, 67000, 85000, 119000,
    189000, 328000, 605000, 1160000, 2270000, 4490000, 8930000, 17800000};

  // Turns each delay into ref_clk cycles, rounding up.
  function automatic amcr_dly_tab_t dly_table();
    amcr_dly_tab_t t;
    for (int i = 0; i < DLY_CODES; i++)
    begin
      t[i] = (DLY_NS[i] * CLK_MHZ + 999) / 1000;
    end
    return t;
  endfunction
  localparam amcr_dly_tab_t DLY_CYC = dly_table();

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef enum logic [1:0] {
    EXC_NORMAL = 2'h0,  // Plain dc excitation.
    EXC_CHOP   = 2'h1,  // Chopped input.
    EXC_AC2W   = 2'h2,  // Two-wire ac bridge.
    EXC_AC4W   = 2'h3   // Four-wire ac bridge.
  } amcr_exc_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_CONV} amcr_seq_t;

  typedef struct packed {
    amcr_exc_t  excitation;
    logic       singleShot;
    logic [3:0] startDelay;
    logic       powerDown;
    logic       statusByteEn;
    logic       checkCodeEn;
    logic       serialAutoResetEn;
  } amcr_cfg_t;

  typedef struct packed {
    logic pgaLow;
    logic pgaHigh;
    logic refLow;
  } amcr_alarm_t;

  typedef struct packed {
    logic [7:0]       convMode;
    logic [7:0]       auxCfg;
    logic [7:0]       pwrIf;
    logic [AUX_N-1:0] auxInSmp;
    amcr_alarm_t      alarm;
    logic             newData;
    amcr_seq_t        seq;
    amcr_dcnt_t       dlyCnt;
    logic             startPrev;
    logic [7:0]       rdData;
    logic             convKick;
    logic             convBusy;
    logic [AUX_N-1:0] auxOut;
    logic [AUX_N-1:0] auxOe;
    amcr_cfg_t        cfg;
  } amcr_state_t;

endpackage
`default_nettype wire

// ===== tb/amcr_host_model.sv
// Host controller model that reaches the mode registers over the register port.
`timescale 1ns/1ps
`default_nettype none
module amcr_host_model
  import amcr_pkg::*;
(
  input  wire logic       ref_clk,    // Register clock.
  output var  logic [7:0] regAddr,    // Address beside a strobe.
  output var  logic [7:0] regWrData,  // Write data.
  output var  logic       regWr,      // Write strobe.
  output var  logic       regRd,      // Read strobe.
  input  wire logic [7:0] regRdData   // Read data, one cycle after the read.
);
  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  // Strobes start low so nothing is requested during reset.
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // One write cycle; idle lines show the inverse so stale values never pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_CONV_MODE)
    begin
      v[CM_RSVD] = 1'b0;  // The reserved top bit is always sent as zero.
      if (v[3:0] > DLY_LAST)
      begin
        v[3:0] = DLY_LAST;  // Reserved delay codes are never sent.
      end
    end
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~v;
  endtask

  // One read cycle; the data are taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the mode configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import amcr_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  localparam amcr_dly_tab_t DELAY_TAB = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14};
  localparam int CYC_LIMIT = 6000;  // Far above the length of all tests.
  logic ref_clk, rst_b, regWr, regRd, startPin, convDone, dataRead, convKick, convBusy;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [AUX_N-1:0] auxPinIn, auxPinOut, auxPinOe, auxConnect;
  amcr_alarm_t alarmIn;
  amcr_cfg_t   cfgOut;
  int nErrors, checksDone, cycles;

  amcr_mode_regs #(.DELAY_CYC(DELAY_TAB)) u_amcr_mode_regs (
    .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .startPin(startPin),
    .convDone(convDone), .dataRead(dataRead), .alarmIn(alarmIn), .auxPinIn(auxPinIn),
    .auxPinOut(auxPinOut), .auxPinOe(auxPinOe), .auxConnect(auxConnect),
    .cfgOut(cfgOut), .convKick(convKick), .convBusy(convBusy));

  amcr_host_model u_amcr_host_model (
    .ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Compares one byte and reports a mismatch at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp)
    begin
      nErrors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Raises the start level and counts edges until the kick shows.
  task automatic kickWait(output int k);
    k = 0;
    @(posedge ref_clk);
    startPin <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (convKick !== 1'b1 && k < 64);
  endtask

  // Ends a conversion with one done pulse, leaving the start level as given.
  task automatic doneConv(input logic keep);
    @(posedge ref_clk);
    convDone <= 1'b1;
    startPin <= keep;
    @(posedge ref_clk);
    convDone <= 1'b0;
  endtask

  // Counts kicks over twenty edges.
  task automatic countKicks(output int n);
    n = 0;
    repeat (20)
    begin
      @(posedge ref_clk);
      #1;
      if (convKick === 1'b1)
      begin
        n++;
      end
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    logic [7:0] d;
    chk("reset delay", 8'h01, {4'h0, cfgOut.startDelay});
    chk("reset exc", 8'h00, {6'h00, cfgOut.excitation});
    chk("reset flags", 8'h00, {3'h0, cfgOut.singleShot, cfgOut.powerDown, cfgOut.statusByteEn,
      cfgOut.checkCodeEn, cfgOut.serialAutoResetEn});
    chk("reset pins", 8'h00, {auxConnect, auxPinOe});
    u_amcr_host_model.rd(ADDR_CONV_MODE, d);
    chk("conv mode reset", RST_CONV_MODE, d);
    u_amcr_host_model.rd(ADDR_AUX_CFG, d);
    chk("aux cfg reset", RST_AUX_CFG, d);
    u_amcr_host_model.rd(ADDR_PWR_IF, d);
    chk("pwr reset", RST_PWR_IF, d);
    u_amcr_host_model.wr(8'h7E, 8'hFF);
    u_amcr_host_model.rd(8'h7E, d);
    chk("unmapped", 8'h00, d);
    $display("test reset done");
  endtask

  task automatic t_fields();
    logic [7:0] v, d;
    for (int i = 0; i < 4; i++)
    begin
      v = {1'b0, i[1:0], i[0], 4'(i + 9)};
      u_amcr_host_model.wr(ADDR_CONV_MODE, v);
      u_amcr_host_model.rd(ADDR_CONV_MODE, d);
      chk("conv mode", v, d);
      chk("exc out", {6'h00, i[1:0]}, {6'h00, cfgOut.excitation});
      chk("single out", {7'h00, i[0]}, {7'h00, cfgOut.singleShot});
      chk("delay out", {4'h0, v[3:0]}, {4'h0, cfgOut.startDelay});
    end
    for (int b = 4; b < 8; b++)
    begin
      v = 8'h01 << b;
      u_amcr_host_model.wr(ADDR_PWR_IF, v);
      u_amcr_host_model.rd(ADDR_PWR_IF, d);
      chk("pwr rb", v, d);
      chk("pwr out", {4'h0, v[7:4]}, {4'h0, cfgOut.powerDown, cfgOut.statusByteEn,
        cfgOut.checkCodeEn, cfgOut.serialAutoResetEn});
    end
    u_amcr_host_model.wr(ADDR_PWR_IF, 8'h00);
    $display("test fields done");
  endtask

  task automatic t_aux();
    logic [7:0] d;
    u_amcr_host_model.wr(ADDR_AUX_CFG, 8'hF5);
    u_amcr_host_model.wr(ADDR_PWR_IF, 8'h08);
    u_amcr_host_model.rd(ADDR_PWR_IF, d);
    chk("pin read", 8'h0D, d);
    chk("connect", 8'h0F, {4'h0, auxConnect});
    chk("oe", 8'h0A, {4'h0, auxPinOe});
    chk("drive", 8'h08, {4'h0, auxPinOut});
    @(posedge ref_clk);
    auxPinIn <= 4'hA;
    u_amcr_host_model.rd(ADDR_PWR_IF, d);
    chk("pin follow", 8'h08, d);
    u_amcr_host_model.wr(ADDR_AUX_CFG, 8'h30);
    u_amcr_host_model.wr(ADDR_PWR_IF, 8'h0F);
    #1;
    chk("part connect", 8'h33, {auxPinOe, auxPinOut});
    u_amcr_host_model.wr(ADDR_PWR_IF, 8'h00);
    $display("test aux done");
  endtask

  task automatic t_delay();
    int k;
    logic [7:0] d;
    for (int c = 0; c < DLY_CODES; c++)
    begin
      u_amcr_host_model.wr(ADDR_CONV_MODE, 8'(c));
      kickWait(k);
      chk("kick delay", 8'(DELAY_TAB[c] + 2), 8'(k));
      doneConv(1'b0);
      #1;
      chk("idle after done", 8'h00, {7'h00, convBusy});
    end
    u_amcr_host_model.rd(ADDR_STATUS, d);
    chk("new data", 8'h04, d);
    @(posedge ref_clk);
    dataRead <= 1'b1;
    @(posedge ref_clk);
    dataRead <= 1'b0;
    u_amcr_host_model.rd(ADDR_STATUS, d);
    chk("data taken", 8'h00, d);
    @(posedge ref_clk);
    alarmIn <= 3'h2;
    @(posedge ref_clk);
    alarmIn <= 3'h0;
    u_amcr_host_model.rd(ADDR_STATUS, d);
    chk("alarm held", 8'h10, d);
    $display("test delay done");
  endtask

  task automatic t_mode();
    int k, n;
    logic [7:0] d;
    for (int m = 0; m < 2; m++)
    begin
      u_amcr_host_model.wr(ADDR_CONV_MODE, {3'h0, m[0], 4'h2});
      kickWait(k);
      doneConv(1'b1);
      countKicks(n);
      chk("kicks after done", 8'(1 - m), 8'(n));
      doneConv(1'b0);
    end
    u_amcr_host_model.rd(ADDR_STATUS, d);
    chk("alarm restart", 8'h04, d);
    $display("test mode done");
  endtask

  task automatic t_pdown();
    int n;
    u_amcr_host_model.wr(ADDR_CONV_MODE, 8'h0D);
    @(posedge ref_clk);
    startPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    u_amcr_host_model.wr(ADDR_PWR_IF, 8'h80);
    countKicks(n);
    chk("kicks in pdown", 8'h00, 8'(n));
    chk("busy in pdown", 8'h00, {7'h00, convBusy});
    @(posedge ref_clk);
    startPin <= 1'b0;
    u_amcr_host_model.wr(ADDR_PWR_IF, 8'h00);
    $display("test pdown done");
  endtask

  // ==========================================================================
  // Clock, sequence and verdict
  // ==========================================================================
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hang short and counts it as a mismatch.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == CYC_LIMIT)
    begin
      nErrors++;
      endSim();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    startPin = 1'b0;
    convDone = 1'b0;
    dataRead = 1'b0;
    alarmIn = '0;
    auxPinIn = 4'h5;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_fields();
    t_aux();
    t_delay();
    t_mode();
    t_pdown();
    endSim();
  end
endmodule
`default_nettype wire
